// ### hdl/fcs_pkg.sv
package fcs_pkg;
  // ----------------------------------------
  // Object indices and subindices
  // ----------------------------------------
  localparam logic [15:0] OBJ_MONITOR = 16'h2022;
  localparam logic [15:0] OBJ_REMOTE_IO = 16'h2026;
  localparam logic [15:0] OBJ_COMMAND = 16'h2060;
  localparam logic [15:0] OBJ_STATUS = 16'h2061;
  localparam logic [7:0] SUB_LOGIC_REG = 8'h1D;
  localparam logic [7:0] SUB_USER_PAGE = 8'h1F;
  localparam logic [7:0] SUB_USER_DISPLAY = 8'h20;
  localparam logic [7:0] SUB_FAN_SPEED = 8'h23;
  localparam logic [7:0] SUB_CTRL_MODE = 8'h24;
  localparam logic [7:0] SUB_CARRIER = 8'h25;
  localparam logic [7:0] SUB_ENC2_LOW = 8'h2B;
  localparam logic [7:0] SUB_ENC2_HIGH = 8'h2C;
  localparam logic [7:0] SUB_INPUT_MAP = 8'h01;
  localparam logic [7:0] SUB_OUTPUT_MAP = 8'h41;
  localparam logic [7:0] SUB_AV_INPUT = 8'h61;
  localparam logic [7:0] SUB_AC_INPUT = 8'h62;
  localparam logic [7:0] SUB_ANALOG_OUT1 = 8'hA1;
  localparam logic [7:0] SUB_ANALOG_OUT2 = 8'hA2;
  localparam logic [7:0] SUB_CMD_WORD = 8'h01;
  localparam logic [7:0] SUB_MODE_SEL = 8'h02;
  localparam logic [7:0] SUB_SETPOINT = 8'h03;
  localparam logic [7:0] SUB_STATUS_WORD = 8'h01;
  localparam logic [7:0] SUB_OUT_FREQ = 8'h03;
  // ----------------------------------------
  // Command word fields
  // ----------------------------------------
  localparam int CMD_RUN = 0;
  localparam int CMD_DIR = 1;
  localparam int CMD_HALT = 3;
  localparam int CMD_HOLD = 4;
  localparam int CMD_INCH = 5;
  localparam int CMD_RSTOP = 6;
  localparam int CMD_POWER = 7;
  localparam int CMD_POS_CLR = 8;
  localparam int CMD_FAULT_CLR = 15;
  // ----------------------------------------
  // Status word fields and bitmap layout
  // ----------------------------------------
  localparam int ST_REACHED = 0;
  localparam int ST_DIR = 1;
  localparam int ST_WARN = 2;
  localparam int ST_ERROR = 3;
  localparam int ST_INCH = 5;
  localparam int ST_RSTOP = 6;
  localparam int ST_POWER = 7;
  localparam int OUT_RELAY = 0;
  localparam int OUT_DIG1 = 3;
  localparam int OUT_DIG2 = 4;
  localparam logic [15:0] OUT_MAP_MASK = 16'h0019;
  localparam int INPUT_BITS = 10;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int RAMP_TICK_NS = 10000;
  localparam int RAMP_TICK_CYC = (RAMP_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] RAMP_STEP = 16'h0001;
  localparam logic [15:0] RAPID_STEP = 16'h0010;
endpackage

// ### hdl/fcs_command_status.sv
`timescale 1ns/1ps
module fcs_command_status
  import fcs_pkg::*;
#(
  parameter int TICK_CYCLES = RAMP_TICK_CYC
)
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic obj_req_in,
  input wire logic obj_wr_in,
  input wire logic [15:0] obj_index_in,
  input wire logic [7:0] obj_sub_in,
  input wire logic [15:0] obj_wdata_in,
  input wire logic forward_input_in,
  input wire logic reverse_input_in,
  input wire logic [7:0] multi_input_in,
  input wire logic [15:0] fan_speed_in,
  input wire logic torque_mode_in,
  input wire logic [15:0] carrier_freq_in,
  input wire logic [31:0] encoder2_count_in,
  input wire logic [15:0] logic_reg_in,
  input wire logic [15:0] user_page_in,
  input wire logic [15:0] user_display_in,
  input wire logic [15:0] analog_voltage_input_in,
  input wire logic [15:0] analog_current_input_in,
  input wire logic pid_enable_in,
  input wire logic [15:0] pid_output_in,
  input wire logic warning_in,
  input wire logic fault_event_in,
  input wire logic [15:0] fault_code_in,
  output logic obj_ack_out,
  output logic obj_err_out,
  output logic [15:0] obj_rdata_out,
  output logic [15:0] freq_cmd_out,
  output logic [15:0] out_freq_out,
  output logic run_reverse_out,
  output logic inch_run_out,
  output logic position_clear_out,
  output logic [15:0] fault_code_out,
  output logic [15:0] mode_select_out,
  output logic relay_output_out,
  output logic digital_output_1_out,
  output logic digital_output_2_out,
  output logic [15:0] analog_output_1_out,
  output logic [15:0] analog_output_2_out
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Moves a frequency one step toward its target without overshoot.
  function automatic logic [15:0] fcs_step(input logic [15:0] cur, input logic [15:0] tgt,
                                           input logic [15:0] step);
    logic [16:0] sum;
    begin
      sum = {1'b0, cur} + {1'b0, step};
      if (cur < tgt)
      begin
        fcs_step = (sum > {1'b0, tgt}) ? tgt : sum[15:0];
      end
      else if ((cur - tgt) < step)
      begin
        fcs_step = tgt;
      end
      else
      begin
        fcs_step = cur - step;
      end
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [INPUT_BITS-1:0] in_s1_q;
  logic [INPUT_BITS-1:0] in_s2_q;
  logic [15:0] cmd_q;
  logic [15:0] mode_q;
  logic [15:0] setpoint_q;
  logic [15:0] out_map_q;
  logic [15:0] aout1_q;
  logic [15:0] aout2_q;
  logic [15:0] fault_q;
  logic [15:0] freq_cmd_q;
  logic [15:0] out_freq_q;
  logic pos_prev_q;
  logic fclr_prev_q;
  logic [15:0] tick_cnt_q;
  logic tick_q;
  logic [15:0] rdata_d;
  logic err_d;
  logic [15:0] status_d;
  logic wr_ok;
  logic fclr_pulse;

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------

  // Terminal inputs come from outside the clock domain and pass two stages.
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      in_s1_q <= '0;
      in_s2_q <= '0;
    end
    else
    begin
      in_s1_q <= {multi_input_in, reverse_input_in, forward_input_in};
      in_s2_q <= in_s1_q;
    end
  end

  // ----------------------------------------
  // Object access decode
  // ----------------------------------------

  // Status flags assembled from the block's own state and the warning input.
  always_comb
  begin
    status_d = REG_RESET;
    status_d[ST_REACHED] = (out_freq_q == freq_cmd_q);
    status_d[ST_DIR] = run_reverse_out;
    status_d[ST_WARN] = warning_in;
    status_d[ST_ERROR] = |fault_q;
    status_d[ST_INCH] = cmd_q[CMD_INCH];
    status_d[ST_RSTOP] = cmd_q[CMD_RSTOP];
    status_d[ST_POWER] = cmd_q[CMD_POWER];
  end

  // Read data and abort for each object; writes to read-only objects abort.
  always_comb
  begin
    rdata_d = REG_RESET;
    err_d = 1'b0;
    if (obj_index_in == OBJ_MONITOR && obj_sub_in == SUB_LOGIC_REG)
      rdata_d = logic_reg_in;
    else if (obj_index_in == OBJ_MONITOR && obj_sub_in == SUB_USER_PAGE)
      rdata_d = user_page_in;
    else if (obj_index_in == OBJ_MONITOR && obj_sub_in == SUB_USER_DISPLAY)
      rdata_d = user_display_in;
    else if (obj_index_in == OBJ_MONITOR && obj_sub_in == SUB_FAN_SPEED)
      rdata_d = fan_speed_in;
    else if (obj_index_in == OBJ_MONITOR && obj_sub_in == SUB_CTRL_MODE)
      rdata_d = {15'h0000, torque_mode_in};
    else if (obj_index_in == OBJ_MONITOR && obj_sub_in == SUB_CARRIER)
      rdata_d = carrier_freq_in;
    else if (obj_index_in == OBJ_MONITOR && obj_sub_in == SUB_ENC2_LOW)
      rdata_d = encoder2_count_in[15:0];
    else if (obj_index_in == OBJ_MONITOR && obj_sub_in == SUB_ENC2_HIGH)
      rdata_d = encoder2_count_in[31:16];
    else if (obj_index_in == OBJ_REMOTE_IO && obj_sub_in == SUB_INPUT_MAP)
      rdata_d = {{(16 - INPUT_BITS){1'b0}}, in_s2_q};
    else if (obj_index_in == OBJ_REMOTE_IO && obj_sub_in == SUB_OUTPUT_MAP)
      rdata_d = out_map_q;
    else if (obj_index_in == OBJ_REMOTE_IO && obj_sub_in == SUB_AV_INPUT)
      rdata_d = analog_voltage_input_in;
    else if (obj_index_in == OBJ_REMOTE_IO && obj_sub_in == SUB_AC_INPUT)
      rdata_d = analog_current_input_in;
    else if (obj_index_in == OBJ_REMOTE_IO && obj_sub_in == SUB_ANALOG_OUT1)
      rdata_d = aout1_q;
    else if (obj_index_in == OBJ_REMOTE_IO && obj_sub_in == SUB_ANALOG_OUT2)
      rdata_d = aout2_q;
    else if (obj_index_in == OBJ_COMMAND && obj_sub_in == SUB_CMD_WORD)
      rdata_d = cmd_q;
    else if (obj_index_in == OBJ_COMMAND && obj_sub_in == SUB_MODE_SEL)
      rdata_d = mode_q;
    else if (obj_index_in == OBJ_COMMAND && obj_sub_in == SUB_SETPOINT)
      rdata_d = setpoint_q;
    else if (obj_index_in == OBJ_STATUS && obj_sub_in == SUB_STATUS_WORD)
      rdata_d = status_d;
    else if (obj_index_in == OBJ_STATUS && obj_sub_in == SUB_OUT_FREQ)
      rdata_d = out_freq_q;
    else
      err_d = 1'b1;
    if (obj_wr_in && !err_d && obj_index_in != OBJ_COMMAND &&
        !(obj_index_in == OBJ_REMOTE_IO && (obj_sub_in == SUB_OUTPUT_MAP ||
          obj_sub_in == SUB_ANALOG_OUT1 || obj_sub_in == SUB_ANALOG_OUT2)))
      err_d = 1'b1;
  end

  assign wr_ok = obj_req_in && obj_wr_in && !err_d;

  // Answer one cycle after each request; write answers return zero data.
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      obj_ack_out <= 1'b0;
      obj_err_out <= 1'b0;
      obj_rdata_out <= REG_RESET;
    end
    else
    begin
      obj_ack_out <= obj_req_in;
      obj_err_out <= obj_req_in && err_d;
      obj_rdata_out <= (obj_req_in && !obj_wr_in && !err_d) ? rdata_d : REG_RESET;
    end
  end

  // ----------------------------------------
  // Writable objects
  // ----------------------------------------

  // Command, mode, setpoint and output objects take accepted writes.
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cmd_q <= REG_RESET;
      mode_q <= REG_RESET;
      setpoint_q <= REG_RESET;
      out_map_q <= REG_RESET;
      aout1_q <= REG_RESET;
      aout2_q <= REG_RESET;
    end
    else if (wr_ok)
    begin
      if (obj_index_in == OBJ_COMMAND && obj_sub_in == SUB_CMD_WORD)
        cmd_q <= obj_wdata_in;
      else if (obj_index_in == OBJ_COMMAND && obj_sub_in == SUB_MODE_SEL)
        mode_q <= obj_wdata_in;
      else if (obj_index_in == OBJ_COMMAND && obj_sub_in == SUB_SETPOINT)
        setpoint_q <= obj_wdata_in;
      else if (obj_index_in == OBJ_REMOTE_IO && obj_sub_in == SUB_OUTPUT_MAP)
        out_map_q <= obj_wdata_in & OUT_MAP_MASK;
      else if (obj_index_in == OBJ_REMOTE_IO && obj_sub_in == SUB_ANALOG_OUT1)
        aout1_q <= obj_wdata_in;
      else if (obj_index_in == OBJ_REMOTE_IO && obj_sub_in == SUB_ANALOG_OUT2)
        aout2_q <= obj_wdata_in;
    end
  end

  // ----------------------------------------
  // Edge-triggered commands and fault store
  // ----------------------------------------
  assign fclr_pulse = cmd_q[CMD_FAULT_CLR] && !fclr_prev_q;

  // Position clear fires once per rising edge; a new fault beats the clear.
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pos_prev_q <= 1'b0;
      fclr_prev_q <= 1'b0;
      position_clear_out <= 1'b0;
      fault_q <= REG_RESET;
    end
    else
    begin
      pos_prev_q <= cmd_q[CMD_POS_CLR];
      fclr_prev_q <= cmd_q[CMD_FAULT_CLR];
      position_clear_out <= cmd_q[CMD_POS_CLR] && !pos_prev_q;
      if (fault_event_in)
        fault_q <= fault_code_in;
      else if (fclr_pulse)
        fault_q <= REG_RESET;
    end
  end

  // ----------------------------------------
  // Ramp tick divider
  // ----------------------------------------

  // One-cycle enable that paces the output frequency ramp.
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tick_cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end
    else if (tick_cnt_q == 16'(TICK_CYCLES - 1))
    begin
      tick_cnt_q <= 16'h0000;
      tick_q <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Frequency command and ramp
  // ----------------------------------------

  // Target follows power, rapid stop, halt, then run in that order.
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      freq_cmd_q <= REG_RESET;
    else if (!cmd_q[CMD_POWER] || cmd_q[CMD_RSTOP] || cmd_q[CMD_HALT])
      freq_cmd_q <= REG_RESET;
    else if (!cmd_q[CMD_RUN])
      freq_cmd_q <= REG_RESET;
    else
      freq_cmd_q <= pid_enable_in ? pid_output_in : setpoint_q;
  end

  // Output frequency drops at once without power, otherwise ramps or holds.
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      out_freq_q <= REG_RESET;
    else if (!cmd_q[CMD_POWER])
      out_freq_q <= REG_RESET;
    else if (cmd_q[CMD_RSTOP])
    begin
      if (tick_q)
        out_freq_q <= fcs_step(out_freq_q, REG_RESET, RAPID_STEP);
    end
    else if (cmd_q[CMD_HOLD] && !cmd_q[CMD_HALT])
      out_freq_q <= out_freq_q;
    else if (tick_q)
      out_freq_q <= fcs_step(out_freq_q, freq_cmd_q, RAMP_STEP);
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------

  // Every output leaves from a flip-flop.
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      freq_cmd_out <= REG_RESET;
      out_freq_out <= REG_RESET;
      run_reverse_out <= 1'b0;
      inch_run_out <= 1'b0;
      fault_code_out <= REG_RESET;
      mode_select_out <= REG_RESET;
      relay_output_out <= 1'b0;
      digital_output_1_out <= 1'b0;
      digital_output_2_out <= 1'b0;
      analog_output_1_out <= REG_RESET;
      analog_output_2_out <= REG_RESET;
    end
    else
    begin
      freq_cmd_out <= freq_cmd_q;
      out_freq_out <= out_freq_q;
      run_reverse_out <= cmd_q[CMD_DIR];
      inch_run_out <= cmd_q[CMD_INCH] && cmd_q[CMD_POWER] && !cmd_q[CMD_RSTOP];
      fault_code_out <= fault_q;
      mode_select_out <= mode_q;
      relay_output_out <= out_map_q[OUT_RELAY];
      digital_output_1_out <= out_map_q[OUT_DIG1];
      digital_output_2_out <= out_map_q[OUT_DIG2];
      analog_output_1_out <= aout1_q;
      analog_output_2_out <= aout2_q;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  input_map_a: assert property (obj_req_in && !obj_wr_in &&
    obj_index_in == OBJ_REMOTE_IO && obj_sub_in == SUB_INPUT_MAP |=>
    obj_rdata_out[15:INPUT_BITS] == 6'h00)
    else $error("input bitmap upper bits not zero");
  output_map_a: assert property (wr_ok && obj_index_in == OBJ_REMOTE_IO &&
    obj_sub_in == SUB_OUTPUT_MAP |=> ##1 relay_output_out == $past(obj_wdata_in[0], 2))
    else $error("relay output did not follow bitmap write");
  run_gate_a: assert property (!cmd_q[CMD_RUN] |=> freq_cmd_q == 16'h0000)
    else $error("frequency command not forced to zero");
  dir_follow_a: assert property (##1 run_reverse_out == $past(cmd_q[CMD_DIR]))
    else $error("direction output wrong");
  halt_stop_a: assert property (cmd_q[CMD_HALT] |=> freq_cmd_q == 16'h0000)
    else $error("halt did not zero the target");
  hold_freeze_a: assert property (cmd_q[CMD_POWER] && cmd_q[CMD_HOLD] &&
    !cmd_q[CMD_RSTOP] && !cmd_q[CMD_HALT] |=> $stable(out_freq_q))
    else $error("output frequency moved while held");
  pos_edge_a: assert property (position_clear_out |-> $past(cmd_q[CMD_POS_CLR]) &&
    !$past(cmd_q[CMD_POS_CLR], 2) && !$past(position_clear_out))
    else $error("position clear not a single edge pulse");
  fault_clr_a: assert property (fclr_pulse && !fault_event_in |=> fault_q == 16'h0000)
    else $error("fault code not cleared");
  power_prio_a: assert property (!cmd_q[CMD_POWER] |=> out_freq_q == 16'h0000 &&
    freq_cmd_q == 16'h0000)
    else $error("power off did not stop output");
  ack_time_a: assert property (obj_req_in |=> obj_ack_out ##1 !obj_ack_out || $past(obj_req_in))
    else $error("object answer timing wrong");

  rapid_stop_c: cover property (cmd_q[CMD_RSTOP] && out_freq_q != 16'h0000 ##[1:1000]
    out_freq_q == 16'h0000);
  pos_clear_c: cover property (position_clear_out);
  fault_clear_c: cover property (fault_q != 16'h0000 ##[1:50] fault_q == 16'h0000);
  write_abort_c: cover property (obj_err_out);

endmodule

// ### sim/fcs_master_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Network master model
// ----------------------------------------
module fcs_master_model
(
  input wire logic clk_sys_in,
  input wire logic ack_in,
  input wire logic err_in,
  input wire logic [15:0] rdata_in,
  output logic req_out,
  output logic wr_out,
  output logic [15:0] index_out,
  output logic [7:0] sub_out,
  output logic [15:0] wdata_out
);
  logic last_err;
  logic [15:0] last_rdata;
  logic timed_out;

  // Idle request port at time zero.
  initial
  begin
    req_out = 1'b0;
    wr_out = 1'b0;
    index_out = 16'h0000;
    sub_out = 8'h00;
    wdata_out = 16'h0000;
    timed_out = 1'b0;
  end

  // Pulses the request and holds the qualifiers until the answer edge.
  task automatic access(input logic w, input logic [15:0] i, input logic [7:0] s,
    input logic [15:0] d);
    int n;
    req_out <= 1'b1;
    wr_out <= w;
    index_out <= i;
    sub_out <= s;
    wdata_out <= d;
    @(posedge clk_sys_in);
    req_out <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk_sys_in);
      n++;
    end
    while (ack_in !== 1'b1 && n < 8);
    timed_out = (ack_in !== 1'b1);
    last_err = err_in;
    last_rdata = rdata_in;
  endtask
endmodule

// ### sim/fcs_command_status_tb_top.sv
`timescale 1ns/1ps
// ----------------------------------------
// Command and status block testbench
// ----------------------------------------
module fcs_command_status_tb_top import fcs_pkg::*;;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic req, wr_en, ack, err, rev_out, inch, pos_clr, relay, dig1, dig2;
  logic [15:0] idx, wdata, rdata, freq_cmd, out_freq, fault_out, mode_sel, aout1, aout2;
  logic pid_en = 1'b0;
  logic [15:0] pid_val = 16'h0009;
  logic [7:0] sub;
  logic forward_input = 1'b1;
  logic reverse_input = 1'b0;
  logic [7:0] multi = 8'hA5;
  logic torque = 1'b1;
  logic warn = 1'b0;
  logic fault_ev = 1'b0;
  logic [15:0] fault_code = 16'h0042;
  logic [31:0] enc2 = 32'h1234_5678;
  logic [15:0] mon [7] = '{16'h1D1D, 16'h1F1F, 16'h2020, 16'h2323, 16'h2525, 16'h6161, 16'h6262};
  logic [7:0] t_sub [10] = '{SUB_LOGIC_REG, SUB_USER_PAGE, SUB_USER_DISPLAY, SUB_FAN_SPEED,
    SUB_CARRIER, SUB_CTRL_MODE, SUB_ENC2_LOW, SUB_ENC2_HIGH, SUB_AV_INPUT, SUB_AC_INPUT};
  logic [15:0] t_exp [10] = '{16'h1D1D, 16'h1F1F, 16'h2020, 16'h2323, 16'h2525, 16'h0001,
    16'h5678, 16'h1234, 16'h6161, 16'h6262};
  int errors = 0;
  int tests_run = 0;
  int pulses = 0;

  // Clock of 100 ns period.
  always #50 clk_sys_in = ~clk_sys_in;

  // Counts position clear pulses.
  always @(posedge clk_sys_in)
  begin
    if (pos_clr === 1'b1)
    begin
      pulses++;
    end
  end

  fcs_master_model i_master (
    .clk_sys_in(clk_sys_in), .ack_in(ack), .err_in(err), .rdata_in(rdata), .req_out(req),
    .wr_out(wr_en), .index_out(idx), .sub_out(sub), .wdata_out(wdata)
  );

  fcs_command_status #(.TICK_CYCLES(2)) i_dut (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .obj_req_in(req), .obj_wr_in(wr_en),
    .obj_index_in(idx), .obj_sub_in(sub), .obj_wdata_in(wdata), .forward_input_in(forward_input),
    .reverse_input_in(reverse_input), .multi_input_in(multi), .fan_speed_in(mon[3]),
    .torque_mode_in(torque), .carrier_freq_in(mon[4]), .encoder2_count_in(enc2),
    .logic_reg_in(mon[0]), .user_page_in(mon[1]), .user_display_in(mon[2]),
    .analog_voltage_input_in(mon[5]), .analog_current_input_in(mon[6]),
    .pid_enable_in(pid_en), .pid_output_in(pid_val), .warning_in(warn),
    .fault_event_in(fault_ev), .fault_code_in(fault_code), .obj_ack_out(ack),
    .obj_err_out(err), .obj_rdata_out(rdata), .freq_cmd_out(freq_cmd),
    .out_freq_out(out_freq), .run_reverse_out(rev_out), .inch_run_out(inch),
    .position_clear_out(pos_clr), .fault_code_out(fault_out), .mode_select_out(mode_sel),
    .relay_output_out(relay), .digital_output_1_out(dig1), .digital_output_2_out(dig2),
    .analog_output_1_out(aout1), .analog_output_2_out(aout2)
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
    input logic [15:0] d);
    i_master.access(w, i, s, d);
    if (i_master.timed_out === 1'b1)
    begin
      errors++;
      conclude();
    end
  endtask

  task automatic rd(input logic [15:0] i, input logic [7:0] s, input logic [15:0] exp);
    acc(1'b0, i, s, 16'h0000);
    check(16'(i_master.last_err), 16'h0000);
    check(i_master.last_rdata, exp);
  endtask

  task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [15:0] d,
    input logic e);
    acc(1'b1, i, s, d);
    check(16'(i_master.last_err), 16'(e));
  endtask

  // Waits a bounded number of cycles for the ramped frequency to settle.
  task automatic wait_out(input logic [15:0] exp, input int limit);
    int n;
    n = 0;
    while (out_freq !== exp && n < limit)
    begin
      @(posedge clk_sys_in);
      n++;
    end
    check(out_freq, exp);
    if (out_freq !== exp)
      conclude();
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    rd(OBJ_REMOTE_IO, SUB_INPUT_MAP, 16'h0295);
    wr(OBJ_REMOTE_IO, SUB_INPUT_MAP, 16'hFFFF, 1'b1);
    wr(OBJ_REMOTE_IO, SUB_OUTPUT_MAP, 16'hFFFF, 1'b0);
    rd(OBJ_REMOTE_IO, SUB_OUTPUT_MAP, 16'h0019);
    check(16'({relay, dig1, dig2}), 16'h0007);
    wr(OBJ_REMOTE_IO, SUB_OUTPUT_MAP, 16'h0008, 1'b0);
    repeat (2) @(posedge clk_sys_in);
    check(16'({relay, dig1, dig2}), 16'h0002);
    for (int k = 0; k < 8; k++)
    begin
      rd(OBJ_MONITOR, t_sub[k], t_exp[k]);
    end
    // Analog inputs read back, analog outputs written and driven, output 1 read back.
    for (int k = 8; k < 10; k++)
    begin
      rd(OBJ_REMOTE_IO, t_sub[k], t_exp[k]);
    end
    wr(OBJ_REMOTE_IO, SUB_ANALOG_OUT1, 16'h1234, 1'b0);
    wr(OBJ_REMOTE_IO, SUB_ANALOG_OUT2, 16'h4321, 1'b0);
    rd(OBJ_REMOTE_IO, SUB_ANALOG_OUT1, 16'h1234);
    check(aout1, 16'h1234);
    check(aout2, 16'h4321);
    torque <= 1'b0;
    rd(OBJ_MONITOR, SUB_CTRL_MODE, 16'h0000);
    wr(OBJ_MONITOR, SUB_FAN_SPEED, 16'h0000, 1'b1);
    wr(OBJ_STATUS, SUB_STATUS_WORD, 16'hFFFF, 1'b1);
    wr(OBJ_COMMAND, SUB_MODE_SEL, 16'h0001, 1'b0);
    @(posedge clk_sys_in);
    check(mode_sel, 16'h0001);
    wr(OBJ_COMMAND, SUB_MODE_SEL, 16'h0000, 1'b0);
    rd(OBJ_COMMAND, SUB_MODE_SEL, 16'h0000);
    wr(OBJ_COMMAND, SUB_SETPOINT, 16'h0005, 1'b0);
    rd(OBJ_COMMAND, SUB_SETPOINT, 16'h0005);
    // Run, stop the run bit, then run in reverse.
    wr(OBJ_COMMAND, SUB_CMD_WORD, 16'h0081, 1'b0);
    repeat (3) @(posedge clk_sys_in);
    check(freq_cmd, 16'h0005);
    wait_out(16'h0005, 40);
    rd(OBJ_STATUS, SUB_STATUS_WORD, 16'h0081);
    wr(OBJ_COMMAND, SUB_CMD_WORD, 16'h0080, 1'b0);
    repeat (3) @(posedge clk_sys_in);
    check(freq_cmd, 16'h0000);
    wait_out(16'h0000, 40);
    wr(OBJ_COMMAND, SUB_CMD_WORD, 16'h0083, 1'b0);
    repeat (3) @(posedge clk_sys_in);
    check(16'(rev_out), 16'h0001);
    wait_out(16'h0005, 40);
    rd(OBJ_STATUS, SUB_STATUS_WORD, 16'h0083);
    // Hold freezes, halt overrides hold, then run ramps to the new setpoint.
    wr(OBJ_COMMAND, SUB_CMD_WORD, 16'h0091, 1'b0);
    wr(OBJ_COMMAND, SUB_SETPOINT, 16'h0014, 1'b0);
    repeat (20) @(posedge clk_sys_in);
    check(out_freq, 16'h0005);
    rd(OBJ_STATUS, SUB_STATUS_WORD, 16'h0080);
    wr(OBJ_COMMAND, SUB_CMD_WORD, 16'h0099, 1'b0);
    wait_out(16'h0000, 40);
    wr(OBJ_COMMAND, SUB_CMD_WORD, 16'h0081, 1'b0);
    wait_out(16'h0014, 100);
    // The regulator output replaces the setpoint while it is selected; rapid stop uses the large step.
    pid_en <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    check(freq_cmd, 16'h0009);
    pid_en <= 1'b0;
    wr(OBJ_COMMAND, SUB_CMD_WORD, 16'h00C1, 1'b0);
    wait_out(16'h0000, 12);
    wr(OBJ_COMMAND, SUB_CMD_WORD, 16'h0081, 1'b0);
    wait_out(16'h0014, 100);
    wr(OBJ_COMMAND, SUB_CMD_WORD, 16'h0001, 1'b0);
    repeat (4) @(posedge clk_sys_in);
    check(out_freq, 16'h0000);
    // Position clear fires once on the rising edge only.
    check(16'(pulses), 16'h0000);
    wr(OBJ_COMMAND, SUB_CMD_WORD, 16'h0181, 1'b0);
    wr(OBJ_COMMAND, SUB_CMD_WORD, 16'h0181, 1'b0);
    repeat (4) @(posedge clk_sys_in);
    check(16'(pulses), 16'h0001);
    wr(OBJ_COMMAND, SUB_CMD_WORD, 16'h00A0, 1'b0);
    repeat (3) @(posedge clk_sys_in);
    check(16'(inch), 16'h0001);
    wait_out(16'h0000, 40);
    rd(OBJ_STATUS, SUB_STATUS_WORD, 16'h00A1);
    // Fault store, then a clear pulse.
    fault_ev <= 1'b1;
    warn <= 1'b1;
    @(posedge clk_sys_in);
    fault_ev <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    check(fault_out, 16'h0042);
    rd(OBJ_STATUS, SUB_STATUS_WORD, 16'h00AD);
    wr(OBJ_COMMAND, SUB_CMD_WORD, 16'h8080, 1'b0);
    wr(OBJ_COMMAND, SUB_CMD_WORD, 16'h0080, 1'b0);
    repeat (2) @(posedge clk_sys_in);
    check(fault_out, 16'h0000);
    conclude();
  end
endmodule
